// >>> cmss_pkg.sv
// constants of the can message store support block
// Notes on behaviour
// R1 - compare each received id against all stored
// R2 - on match store data, set ready, interrupt
// R3 - no match: drop, touch no buffer
// R4 - auto answer remote only if stored rtr
// R5 - ids may be rewritten at any time
// R6 - host data goes through 64-bit shadow
// R7 - shadow loads on first read, byte 7
// R8 - write of byte 0 stores shadow
// R9 - host accesses byte 7 first, byte 0 last
// R10 - host never mixes reads and writes
// R11 - check echo, mismatch sends error frame
// R12 - each mismatch adds one to counter
// R13 - counter at four sets flag, interrupt
// R14 - counter at four forces bus off
// R15 - counter clears on reset, host accessible
// R16 - messages 0-7 capture timer on receive
// R17 - overflow flag sticky, no interrupt
// R18 - prescale 1/32 1/64 1/128 1/256
// R19 - timer starts at zero, free running
// R20 - each port pin direction from register
// R21 - latch register drives, pin register reads
// R22 - digital bit selects direct rx input
// R23 - data buffers ascending, eight bytes each
// R24 - stamps and descriptors not reset
// R25 - stamp captured with receive ready
`default_nettype none
package cmss_pkg;
  // register indices, byte address is four times the index
  localparam logic [7:0] BUS_CONFIG_TWO = 8'h01;
  localparam logic [7:0] RX_READY_LO = 8'h04;
  localparam logic [7:0] RX_READY_HI = 8'h05;
  localparam logic [7:0] RX_IRQ_EN_LO = 8'h06;
  localparam logic [7:0] RX_IRQ_EN_HI = 8'h07;
  localparam logic [7:0] IRQ_MASK_REGISTER = 8'h0a;
  localparam logic [7:0] IRQ_FLAGS = 8'h11;
  localparam logic [7:0] CONTROL = 8'h12;
  localparam logic [7:0] CHECK_ERROR_COUNTER = 8'h15;
  localparam logic [7:0] STAMP_TIMER_HI = 8'h1c;
  localparam logic [7:0] STAMP_TIMER_LO = 8'h1d;
  localparam logic [7:0] PORT0_DIR = 8'h28;
  localparam logic [7:0] PORT0_PIN = 8'h29;
  localparam logic [7:0] PORT0_LATCH = 8'h2a;
  localparam logic [7:0] PORT1_DIR = 8'h2c;
  localparam logic [7:0] PORT1_PIN = 8'h2d;
  localparam logic [7:0] PORT1_LATCH = 8'h2e;
  localparam logic [7:0] STAMP_BASE = 8'h30;
  localparam logic [7:0] DESC_BASE = 8'h40;
  localparam logic [7:0] DATA_BASE = 8'h80;
  // field positions
  localparam int DIGITAL_RX_SELECT_BIT = 0;
  localparam int CHECK_ERROR_IRQ_FLAG_BIT = 0;
  localparam int CHECK_ERROR_IRQ_ENABLE_BIT = 0;
  localparam int STAMP_TIMER_OVERFLOW_BIT = 0;
  localparam int STAMP_PRESCALE_LSB = 1;
  localparam int DESC_RTR_BIT = 4;
  // counts and reset values
  localparam logic [7:0] CHECK_ERROR_LIMIT = 8'h04;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] TIMER_RESET = 16'h0000;
  localparam int MSG_COUNT = 16;
  localparam int STAMP_COUNT = 8;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage : cmss_pkg
`default_nettype wire

// >>> cmss_id_match.sv
// identifier compare against all stored descriptors
`timescale 1ns/1ps
`default_nettype none
module cmss_id_match (
  input wire logic [255:0] descFlat, // 16 descriptors, 16 bits each
  input wire logic [10:0] rxId, // received identifier
  output logic hit, // some entry matches
  output logic [3:0] hitIdx, // lowest matching entry
  output logic hitRtr // stored rtr bit of that entry
);
  logic [15:0] eq;
  // parallel compare of every entry
  genvar g;
  generate
    for (g = 0; g < 16; g++)
    begin : gCmp
      assign eq[g] = descFlat[g*16+5 +: 11] == rxId; // R1
    end
  endgenerate
  // priority pick of the lowest hit
  always_comb
  begin
    hit = |eq;
    hitIdx = 4'h0;
    for (int i = 15; i >= 0; i--)
    begin
      if (eq[i])
      begin
        hitIdx = 4'(i);
      end
    end
    hitRtr = descFlat[{hitIdx, 4'h4}];
  end
endmodule : cmss_id_match
`default_nettype wire

// >>> cmss_core.sv
// message store support top: axi4-lite registers, shadow, check, stamp, ports
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module cmss_core (
  input wire logic clk, // 100 MHz clock
  input wire logic rst, // async reset, active high
  input wire logic [31:0] awaddr, // axi write address
  input wire logic awvalid, // axi
  output logic awready, // axi
  input wire logic [31:0] wdata, // axi write data
  input wire logic [3:0] wstrb, // axi
  input wire logic wvalid, // axi
  output logic wready, // axi
  output logic [1:0] bresp, // axi
  output logic bvalid, // axi
  input wire logic bready, // axi
  input wire logic [31:0] araddr, // axi read address
  input wire logic arvalid, // axi
  output logic arready, // axi
  output logic [31:0] rdata, // axi
  output logic [1:0] rresp, // axi
  output logic rvalid, // axi
  input wire logic rready, // axi
  input wire logic rxValid, // pulse: frame received
  input wire logic [10:0] rxId, // received identifier
  input wire logic rxRemote, // received frame is remote request
  input wire logic [63:0] rxData, // received data field
  output logic replyReq, // pulse: answer remote request
  output logic [3:0] replyIdx, // message to answer with
  input wire logic checkMismatch, // pulse: echo differs from store
  output logic errorFrame, // pulse: send error frame
  output logic busOff, // level: forced bus off
  output logic irq, // level: interrupt request
  input wire logic busTick, // bus clock enable pulse
  input wire logic rxComp, // comparator rx level
  input wire logic rxDigital, // direct digital rx level
  output logic rxBit, // selected rx level
  input wire logic [7:0] port0In, // port 0 pin levels
  output logic [7:0] port0Out, // port 0 drive values
  output logic [7:0] port0Oe, // port 0 drive enables
  input wire logic [7:0] port1In, // port 1 pin levels
  output logic [7:0] port1Out, // port 1 drive values
  output logic [7:0] port1Oe // port 1 drive enables
);
  // =====================================================
  // state
  logic [63:0] dataMem [16]; // R23
  logic [15:0] descMem [16];
  logic [15:0] stampMem [8];
  logic [63:0] shadow_q;
  logic [7:0] busCfg_q, imask_q, ctrl_q, check_error_counter_q, dir0_q, dir1_q, lat0_q, lat1_q;
  logic [15:0] rrdy_q, rien_q, timer_q;
  logic tcFlag_q, busOff_q;
  logic [7:0] pre_q;
  logic [3:0] rdField_q;
  logic rdSeq_q;
  logic [255:0] descFlat;
  logic hit, hitRtr;
  logic [3:0] hitIdx;

  // =====================================================
  // bus handshake
  logic wrEn, rdEn;
  logic [7:0] wIdx, rIdx, wByte;
  assign wrEn = awvalid && wvalid && !bvalid;
  assign awready = wrEn;
  assign wready = wrEn;
  assign rdEn = arvalid && !rvalid;
  assign arready = rdEn;
  assign wIdx = awaddr[9:2];
  assign rIdx = araddr[9:2];
  assign wByte = wstrb[0] ? wdata[7:0] : 8'h00;
  logic wOk;
  assign wOk = wrEn && wstrb[0] && awaddr[31:10] == 22'h0;

  function automatic logic isWr(input logic [7:0] a);
    isWr = wOk && wIdx == a;
  endfunction : isWr

  // write response
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bvalid <= 1'b0;
      bresp <= 2'h0;
    end
    else if (wrEn)
    begin
      bvalid <= 1'b1;
      bresp <= awaddr[31:10] == 22'h0 ? cmss_pkg::AXI_OKAY : cmss_pkg::AXI_SLVERR;
    end
    else if (bready)
    begin
      bvalid <= 1'b0;
    end
  end

  // =====================================================
  // identifier match
  generate
    for (genvar g = 0; g < 16; g++)
    begin : gFlat
      assign descFlat[g*16 +: 16] = descMem[g];
    end
  endgenerate

  cmss_id_match uMatch (
    .descFlat(descFlat),
    .rxId(rxId),
    .hit(hit),
    .hitIdx(hitIdx),
    .hitRtr(hitRtr)
  );

  logic rxStore;
  assign rxStore = rxValid && hit && !rxRemote; // R3

  // remote answer only with stored rtr set
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      replyReq <= 1'b0;
      replyIdx <= 4'h0;
    end
    else
    begin
      replyReq <= rxValid && rxRemote && hit && hitRtr; // R4
      replyIdx <= hitIdx;
    end
  end

  // =====================================================
  // descriptors, data store and stamps, kept over reset
  logic [3:0] wField;
  assign wField = wIdx[6:3];
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < 16; i++)
    begin
      if (isWr(cmss_pkg::DESC_BASE + 8'(2 * i)))
      begin
        descMem[i][15:8] <= wByte; // R5 R24
      end
      if (isWr(cmss_pkg::DESC_BASE + 8'(2 * i + 1)))
      begin
        descMem[i][7:0] <= wByte; // R5
      end
    end
    if (rxStore)
    begin
      dataMem[hitIdx] <= rxData; // R2
      if (hitIdx < 4'(cmss_pkg::STAMP_COUNT))
      begin
        stampMem[hitIdx[2:0]] <= timer_q; // R16 R25
      end
    end
    if (wOk && wIdx[7] && wIdx[2:0] == 3'h0)
    begin
      dataMem[wField] <= {shadow_q[63:8], wByte}; // R8
    end
    for (int i = 0; i < 16; i++)
    begin
      if (isWr(cmss_pkg::STAMP_BASE + 8'(i)))
      begin
        if (i[0])
        begin
          stampMem[i / 2][7:0] <= wByte;
        end
        else
        begin
          stampMem[i / 2][15:8] <= wByte;
        end
      end
    end
  end

  // =====================================================
  // shadow register
  logic rdData, rdLoad;
  logic [3:0] rField;
  assign rdData = rdEn && rIdx[7] && araddr[31:10] == 22'h0;
  assign rField = rIdx[6:3];
  assign rdLoad = rdData && (!rdSeq_q || rdField_q != rField || rIdx[2:0] == 3'h7); // R7

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      shadow_q <= 64'h0;
      rdSeq_q <= 1'b0;
      rdField_q <= 4'h0;
    end
    else
    begin
      if (rdLoad)
      begin
        shadow_q <= dataMem[rField]; // R6 R7
      end
      else if (wOk && wIdx[7])
      begin
        shadow_q[{wIdx[2:0], 3'h0} +: 8] <= wByte; // R6
      end
      if (rdData)
      begin
        rdSeq_q <= 1'b1;
        rdField_q <= rField;
      end
      else if (wrEn)
      begin
        rdSeq_q <= 1'b0;
      end
    end
  end

  // =====================================================
  // read data
  logic [7:0] rdByte;
  always_comb
  begin
    rdByte = 8'h00;
    if (rIdx[7])
    begin
      rdByte = rdLoad ? dataMem[rField][{rIdx[2:0], 3'h0} +: 8]
                      : shadow_q[{rIdx[2:0], 3'h0} +: 8];
    end
    else if (rIdx[7:5] == 3'h2)
    begin
      rdByte = rIdx[0] ? descMem[rIdx[4:1]][7:0] : descMem[rIdx[4:1]][15:8];
    end
    else if (rIdx[7:4] == 4'h3)
    begin
      rdByte = rIdx[0] ? stampMem[rIdx[3:1]][7:0] : stampMem[rIdx[3:1]][15:8];
    end
    else
    begin
      unique case (rIdx)
        cmss_pkg::BUS_CONFIG_TWO: rdByte = busCfg_q;
        cmss_pkg::RX_READY_LO: rdByte = rrdy_q[7:0];
        cmss_pkg::RX_READY_HI: rdByte = rrdy_q[15:8];
        cmss_pkg::RX_IRQ_EN_LO: rdByte = rien_q[7:0];
        cmss_pkg::RX_IRQ_EN_HI: rdByte = rien_q[15:8];
        cmss_pkg::IRQ_MASK_REGISTER: rdByte = imask_q;
        cmss_pkg::IRQ_FLAGS: rdByte = {7'h00, tcFlag_q};
        cmss_pkg::CONTROL: rdByte = ctrl_q;
        cmss_pkg::CHECK_ERROR_COUNTER: rdByte = check_error_counter_q; // R15
        cmss_pkg::STAMP_TIMER_HI: rdByte = timer_q[15:8]; // R19
        cmss_pkg::STAMP_TIMER_LO: rdByte = timer_q[7:0];
        cmss_pkg::PORT0_DIR: rdByte = dir0_q;
        cmss_pkg::PORT0_PIN: rdByte = port0In; // R21
        cmss_pkg::PORT0_LATCH: rdByte = lat0_q; // R21
        cmss_pkg::PORT1_DIR: rdByte = dir1_q;
        cmss_pkg::PORT1_PIN: rdByte = port1In;
        cmss_pkg::PORT1_LATCH: rdByte = lat1_q;
        default: rdByte = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= 2'h0;
    end
    else if (rdEn)
    begin
      rvalid <= 1'b1;
      rdata <= {24'h0, rdByte};
      rresp <= araddr[31:10] == 22'h0 ? cmss_pkg::AXI_OKAY : cmss_pkg::AXI_SLVERR;
    end
    else if (rready)
    begin
      rvalid <= 1'b0;
    end
  end

  // =====================================================
  // plain control registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      busCfg_q <= cmss_pkg::REG_RESET;
      imask_q <= cmss_pkg::REG_RESET;
      rien_q <= 16'h0;
      dir0_q <= cmss_pkg::REG_RESET;
      dir1_q <= cmss_pkg::REG_RESET;
      lat0_q <= cmss_pkg::REG_RESET;
      lat1_q <= cmss_pkg::REG_RESET;
    end
    else
    begin
      if (isWr(cmss_pkg::BUS_CONFIG_TWO)) busCfg_q <= wByte;
      if (isWr(cmss_pkg::IRQ_MASK_REGISTER)) imask_q <= wByte;
      if (isWr(cmss_pkg::RX_IRQ_EN_LO)) rien_q[7:0] <= wByte;
      if (isWr(cmss_pkg::RX_IRQ_EN_HI)) rien_q[15:8] <= wByte;
      if (isWr(cmss_pkg::PORT0_DIR)) dir0_q <= wByte;
      if (isWr(cmss_pkg::PORT1_DIR)) dir1_q <= wByte;
      if (isWr(cmss_pkg::PORT0_LATCH)) lat0_q <= wByte;
      if (isWr(cmss_pkg::PORT1_LATCH)) lat1_q <= wByte;
    end
  end

  // receive ready: host writes zero to clear, new reception wins
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rrdy_q <= 16'h0;
    end
    else
    begin
      for (int i = 0; i < 16; i++)
      begin
        if (rxStore && hitIdx == 4'(i))
        begin
          rrdy_q[i] <= 1'b1; // R2
        end
        else if (isWr(i < 8 ? cmss_pkg::RX_READY_LO : cmss_pkg::RX_READY_HI))
        begin
          rrdy_q[i] <= rrdy_q[i] & wByte[i % 8];
        end
      end
    end
  end

  // =====================================================
  // transmit check
  logic [7:0] tcecNext;
  assign tcecNext = check_error_counter_q + 8'h01;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      check_error_counter_q <= cmss_pkg::REG_RESET; // R15
      tcFlag_q <= 1'b0;
      busOff_q <= 1'b0;
      errorFrame <= 1'b0;
    end
    else
    begin
      errorFrame <= checkMismatch; // R11
      if (checkMismatch)
      begin
        check_error_counter_q <= tcecNext; // R12
      end
      else if (isWr(cmss_pkg::CHECK_ERROR_COUNTER))
      begin
        check_error_counter_q <= wByte; // R15
      end
      if (checkMismatch && tcecNext == cmss_pkg::CHECK_ERROR_LIMIT)
      begin
        tcFlag_q <= 1'b1; // R13
        busOff_q <= 1'b1; // R14
      end
      else if (isWr(cmss_pkg::IRQ_FLAGS))
      begin
        tcFlag_q <= wByte[cmss_pkg::CHECK_ERROR_IRQ_FLAG_BIT];
      end
    end
  end

  // =====================================================
  // time stamp timer
  function automatic logic [7:0] preMask(input logic [1:0] sel);
    preMask = 8'hff >> (2'h3 - sel); // 31 63 127 255
  endfunction : preMask

  logic [1:0] preSel;
  logic stampTick;
  assign preSel = ctrl_q[cmss_pkg::STAMP_PRESCALE_LSB +: 2];
  assign stampTick = busTick && (pre_q & preMask(preSel)) == preMask(preSel); // R18

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pre_q <= 8'h00;
      timer_q <= cmss_pkg::TIMER_RESET; // R19
      ctrl_q <= cmss_pkg::REG_RESET;
    end
    else
    begin
      if (busTick)
      begin
        pre_q <= stampTick ? 8'h00 : pre_q + 8'h01;
      end
      if (isWr(cmss_pkg::STAMP_TIMER_HI))
      begin
        timer_q[15:8] <= wByte; // R19
      end
      else if (isWr(cmss_pkg::STAMP_TIMER_LO))
      begin
        timer_q[7:0] <= wByte;
      end
      else if (stampTick)
      begin
        timer_q <= timer_q + 16'h0001; // R19
      end
      if (isWr(cmss_pkg::CONTROL))
      begin
        ctrl_q <= wByte;
      end
      if (stampTick && timer_q == 16'hffff)
      begin
        ctrl_q[cmss_pkg::STAMP_TIMER_OVERFLOW_BIT] <= 1'b1; // R17
      end
    end
  end

  // =====================================================
  // outputs
  assign busOff = busOff_q;
  assign irq = (tcFlag_q && imask_q[cmss_pkg::CHECK_ERROR_IRQ_ENABLE_BIT])
            || |(rrdy_q & rien_q); // R2 R13
  assign rxBit = busCfg_q[cmss_pkg::DIGITAL_RX_SELECT_BIT] ? rxDigital : rxComp; // R22
  assign port0Out = lat0_q; // R21
  assign port1Out = lat1_q;
  assign port0Oe = dir0_q; // R20
  assign port1Oe = dir1_q; // R20

  // =====================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence mismatchAtLimit;
    checkMismatch && check_error_counter_q == 8'h03;
  endsequence

  counter_step_a: assert property (checkMismatch |=> check_error_counter_q == $past(check_error_counter_q) + 8'h01) // R12
    else $error("check counter did not step");
  limit_flag_a: assert property (mismatchAtLimit |=> tcFlag_q && busOff) // R13 R14
    else $error("limit did not set flag and bus off");
  error_frame_a: assert property (checkMismatch |=> errorFrame) // R11
    else $error("no error frame after mismatch");
  rx_ready_a: assert property (rxStore |=> rrdy_q[$past(hitIdx)]) // R2
    else $error("receive ready not set");
  no_match_a: assert property (rxValid && !hit && !wrEn |=> rrdy_q == $past(rrdy_q)) // R3
    else $error("unmatched frame changed ready");
  reply_rtr_a: assert property (replyReq |-> $past(hitRtr && rxRemote)) // R4
    else $error("remote answer without stored rtr");
  overflow_a: assert property (stampTick && timer_q == 16'hffff && !wrEn
    |=> ctrl_q[0] && timer_q == 16'h0000) // R17
    else $error("overflow flag not set");
  rx_select_a: assert property (rxBit == (busCfg_q[0] ? rxDigital : rxComp)) // R22
    else $error("rx source wrong");
  byte7_load_a: assert property (rdData && rIdx[2:0] == 3'h7 |=> shadow_q == $past(dataMem[rField])) // R7
    else $error("shadow not loaded");
endmodule : cmss_core
`default_nettype wire

// >>> cmss_can_side.sv
// far-side model: frame source, echo checker and bus clock enable
`timescale 1ns/1ps
`default_nettype none
module cmss_can_side (
  input wire logic clk, // block clock
  output logic rxValid, // frame strobe
  output logic [10:0] rxId, // frame identifier
  output logic rxRemote, // remote request flag
  output logic [63:0] rxData, // data field
  output logic checkMismatch, // echo mismatch pulse
  output logic busTick // bus clock enable
);
  // ==========================================
  // idle lines
  initial
  begin
    rxValid = 1'b0;
    rxId = 11'h000;
    rxRemote = 1'b0;
    rxData = 64'h0;
    checkMismatch = 1'b0;
    busTick = 1'b0;
  end
  // one frame, then released lines show the inverse of the last value
  task automatic frame(input logic [10:0] id, input logic rem, input logic [63:0] d);
    @(posedge clk);
    rxValid <= 1'b1;
    rxId <= id;
    rxRemote <= rem;
    rxData <= d;
    @(posedge clk);
    rxValid <= 1'b0;
    rxId <= ~id;
    rxRemote <= ~rem;
    rxData <= ~d;
  endtask : frame
  // echo of a sent frame differs from the store
  task automatic echoFail();
    @(posedge clk);
    checkMismatch <= 1'b1;
    @(posedge clk);
    checkMismatch <= 1'b0;
  endtask : echoFail
  // n consecutive bus clock enables
  task automatic ticks(input int n);
    @(posedge clk);
    busTick <= 1'b1;
    repeat (n - 1) @(posedge clk);
    @(posedge clk);
    busTick <= 1'b0;
  endtask : ticks
endmodule : cmss_can_side
`default_nettype wire

// >>> cmss_core_tb.sv
// self-checking bench of the message store support block
`timescale 1ns/1ps
`default_nettype none
module cmss_core_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, seed = 32'h0000002b, r;
  logic [3:0] wstrb = '0, replyIdx, lastIdx = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, replyReq, errorFrame, busOff, irq, rxBit;
  logic [1:0] bresp, rresp;
  logic rxValid, rxRemote, checkMismatch, busTick, rxComp = 0, rxDigital = 0;
  logic [10:0] rxId;
  logic [63:0] rxData, d1, d2;
  logic [7:0] p0Ext = '0, p1Ext = '0, port0In, port1In, port0Out, port1Out, port0Oe, port1Oe;
  logic [33:0] expQ[$];
  int err_total = 0, compares = 0, nRep = 0, nErr = 0, i;
  // ==========================================
  // clock, pins resolved from all drivers
  always #5 clk = ~clk;
  assign port0In = (port0Oe & port0Out) | (~port0Oe & p0Ext);
  assign port1In = (port1Oe & port1Out) | (~port1Oe & p1Ext);
  cmss_can_side i_can (.clk, .rxValid, .rxId, .rxRemote, .rxData, .checkMismatch, .busTick);
  cmss_core i_dut (.clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .rxValid, .rxId, .rxRemote, .rxData, .replyReq, .replyIdx,
    .checkMismatch, .errorFrame, .busOff, .irq, .busTick, .rxComp, .rxDigital, .rxBit,
    .port0In, .port0Out, .port0Oe, .port1In, .port1Out, .port1Oe);
  // ==========================================
  // helpers
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [7:0] dA(input int m, input int b);
    return cmss_pkg::DATA_BASE + 8'(8 * m + b);
  endfunction : dA
  task automatic end_of_test();
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    compares++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic lim(input int n);
    if (n >= 200)
    begin
      err_total++;
      $display("MISMATCH %0t bus wait ran out", $time);
      end_of_test();
    end
  endtask : lim
  // ==========================================
  // axi4-lite master
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    int n;
    @(posedge clk);
    awaddr <= {22'h0, idx, 2'h0};
    wdata <= {24'h0, v};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do @(posedge clk); while (awready !== 1'b1 && ++n < 200);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge clk); while (bvalid !== 1'b1 && ++n < 200);
    bready <= 1'b0;
    chk(64'(bresp), 64'(cmss_pkg::AXI_OKAY));
    lim(n);
  endtask : wr
  task automatic rdA(input logic [31:0] a, input logic [33:0] e);
    int n;
    @(posedge clk);
    expQ.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do @(posedge clk); while (arready !== 1'b1 && ++n < 200);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1 && ++n < 200);
    rready <= 1'b0;
    lim(n);
  endtask : rdA
  task automatic rd(input logic [7:0] idx, input logic [7:0] v);
    rdA({22'h0, idx, 2'h0}, {cmss_pkg::AXI_OKAY, 24'h0, v});
  endtask : rd
  // ==========================================
  // monitor: read answers against the oldest note, pulse counts
  always @(posedge clk)
  begin
    if (rvalid === 1'b1 && rready === 1'b1)
      chk(64'({rresp, rdata}), 64'(expQ.pop_front()));
    if (replyReq === 1'b1)
    begin
      nRep++;
      lastIdx = replyIdx;
    end
    if (errorFrame === 1'b1)
      nErr++;
  end
  // ==========================================
  // main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(cmss_pkg::CHECK_ERROR_COUNTER, 8'h00);
    rd(cmss_pkg::STAMP_TIMER_HI, 8'h00);
    rd(8'h0b, 8'h00);
    rdA(32'h00000400, {cmss_pkg::AXI_SLVERR, 32'h0});
    // every descriptor known, then two reprogrammed
    for (i = 0; i < 16; i++)
    begin
      wr(cmss_pkg::DESC_BASE + 8'(2 * i), 8'h80 + 8'(i));
      wr(cmss_pkg::DESC_BASE + 8'(2 * i + 1), 8'h08);
    end
    wr(cmss_pkg::DESC_BASE + 8'h04, 8'h24);
    wr(cmss_pkg::DESC_BASE + 8'h05, 8'h68);
    wr(cmss_pkg::DESC_BASE + 8'h06, 8'h2a);
    wr(cmss_pkg::DESC_BASE + 8'h07, 8'hb8);
    wr(cmss_pkg::STAMP_TIMER_HI, 8'h5a);
    wr(cmss_pkg::STAMP_TIMER_LO, 8'h3c);
    wr(cmss_pkg::RX_IRQ_EN_LO, 8'h04);
    d1 = {rnd(), rnd()};
    i_can.frame(11'h123, 1'b0, d1);
    repeat (2) @(posedge clk);
    chk(64'(irq), 64'h1);
    rd(cmss_pkg::RX_READY_LO, 8'h04);
    rd(cmss_pkg::STAMP_BASE + 8'h04, 8'h5a);
    rd(cmss_pkg::STAMP_BASE + 8'h05, 8'h3c);
    // shadow keeps the first frame while a second one lands
    rd(dA(2, 7), d1[63:56]);
    d2 = {rnd(), rnd()};
    i_can.frame(11'h123, 1'b0, d2);
    for (i = 6; i >= 0; i--) rd(dA(2, i), d1[8*i +: 8]);
    for (i = 7; i >= 0; i--) rd(dA(2, i), d2[8*i +: 8]);
    i_can.frame(11'h7ff, 1'b0, d1);
    for (i = 7; i >= 0; i--) rd(dA(2, i), d2[8*i +: 8]);
    rd(cmss_pkg::RX_READY_LO, 8'h04);
    wr(cmss_pkg::RX_READY_LO, 8'h00);
    chk(64'(irq), 64'h0);
    i_can.frame(11'h155, 1'b1, d1);
    i_can.frame(11'h123, 1'b1, d1);
    repeat (3) @(posedge clk);
    chk(64'({nRep[7:0], lastIdx}), 64'h013);
    // host data through the shadow, most significant byte first
    for (i = 7; i >= 0; i--) wr(dA(4, i), d1[8*i +: 8]);
    for (i = 7; i >= 0; i--) rd(dA(4, i), d1[8*i +: 8]);
    // transmit check, masked and unmasked
    repeat (4) i_can.echoFail();
    repeat (2) @(posedge clk);
    chk(64'({busOff, irq}), 64'h2);
    rd(cmss_pkg::IRQ_FLAGS, 8'h01);
    wr(cmss_pkg::IRQ_FLAGS, 8'h00);
    wr(cmss_pkg::CHECK_ERROR_COUNTER, 8'h00);
    wr(cmss_pkg::IRQ_MASK_REGISTER, 8'h01);
    repeat (3) i_can.echoFail();
    rd(cmss_pkg::CHECK_ERROR_COUNTER, 8'h03);
    chk(64'(irq), 64'h0);
    i_can.echoFail();
    repeat (2) @(posedge clk);
    chk(64'({busOff, irq, nErr[7:0]}), 64'h308);
    rd(cmss_pkg::CHECK_ERROR_COUNTER, 8'h04);
    wr(cmss_pkg::IRQ_FLAGS, 8'h00);
    // stamp timer: each divider, then a wrap
    for (i = 0; i < 5; i++)
    begin
      wr(cmss_pkg::CONTROL, 8'((i % 4) << 1));
      i_can.ticks(256);
      wr(cmss_pkg::STAMP_TIMER_HI, (i == 4) ? 8'hff : 8'h00);
      wr(cmss_pkg::STAMP_TIMER_LO, (i == 4) ? 8'hff : 8'h00);
      i_can.ticks(32 << (i % 4));
      rd(cmss_pkg::STAMP_TIMER_LO, (i == 4) ? 8'h00 : 8'h01);
      rd(cmss_pkg::CONTROL, 8'((i % 4) << 1) | ((i == 4) ? 8'h01 : 8'h00));
    end
    chk(64'(irq), 64'h0);
    wr(cmss_pkg::CONTROL, 8'h00);
    rd(cmss_pkg::CONTROL, 8'h00);
    // ports with random direction, latch and outside levels
    for (i = 0; i < 2; i++)
    begin
      r = rnd();
      if (i == 0) p0Ext <= r[23:16];
      else p1Ext <= r[23:16];
      wr(cmss_pkg::PORT0_DIR + 8'(4 * i), r[7:0]);
      wr(cmss_pkg::PORT0_LATCH + 8'(4 * i), r[15:8]);
      rd(cmss_pkg::PORT0_LATCH + 8'(4 * i), r[15:8]);
      rd(cmss_pkg::PORT0_PIN + 8'(4 * i), (r[7:0] & r[15:8]) | (~r[7:0] & r[23:16]));
      chk(64'(i ? {port1Oe, port1Out} : {port0Oe, port0Out}), 64'({r[7:0], r[15:8]}));
    end
    rxComp <= 1'b1;
    wr(cmss_pkg::BUS_CONFIG_TWO, 8'h01);
    chk(64'(rxBit), 64'h0);
    wr(cmss_pkg::BUS_CONFIG_TWO, 8'h00);
    chk(64'(rxBit), 64'h1);
    // mid-run reset: stamps survive, counter clears
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(cmss_pkg::STAMP_BASE + 8'h04, 8'h5a);
    rd(cmss_pkg::CHECK_ERROR_COUNTER, 8'h00);
    chk(64'(busOff), 64'h0);
    repeat (4) @(posedge clk);
    end_of_test();
  end
endmodule : cmss_core_tb
`default_nettype wire
